// ---- rtl/spi_cfg_defs.svh ----
// offsets, field positions, reset values and timing counts of the serial configuration port
// assumes it is included by bare name from the package and the design files
`ifndef SPI_CFG_DEFS_SVH
`define SPI_CFG_DEFS_SVH

// address space
`define SPI_ADDR_W        13
`define REG_PORT_CFG      13'h000
`define REG_CHIP_ID       13'h001
`define REG_CHIP_GRADE    13'h002
`define REG_FUNC_FIRST    13'h008
`define REG_FUNC_LAST     13'h13a
`define REG_SHADOW_XFER   13'h0ff
`define FUNC_REG_COUNT    307

// port configuration register fields
`define CFG_RESET         8'h18
`define CFG_ADDR13_MASK   8'h18
`define CFG_LSB_HI        6
`define CFG_LSB_LO        1
`define CFG_SRST_HI       5
`define CFG_SRST_LO       2

// transfer register
`define XFER_BIT          0

// framing
`define INSTR_BITS        16
`define BYTE_BITS         8
`define INSTR_LAST        4'hf
`define BYTE_LAST         4'h7

// stall limit: a select-high gap longer than this ends the frame
`define CLK_PERIOD_NS     20
`define STALL_NS          1280
`define STALL_CYCLES      ((`STALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/spi_cfg_pkg.sv ----
// types shared by the serial configuration port
// assumes spi_cfg_defs.svh is on the include path
`include "spi_cfg_defs.svh"

package spi_cfg_pkg;

	// where the link stands inside a frame
	typedef enum logic {
		PH_INSTR,
		PH_DATA
	} link_phase_t;

	// sixteen-bit instruction word, first bit first
	typedef struct packed {
		logic                     rd;       // 1 = read
		logic [1:0]               word_len; // carried, not used
		logic [`SPI_ADDR_W-1:0]   addr;     // start address
	} instr_t;

	// state shown to the converter side
	typedef struct packed {
		logic lsb_first;   // bit order in force
		logic xfer_busy;   // transfer request in flight
		logic port_idle;   // select held high past the stall limit
	} port_status_t;

endpackage

// ---- rtl/sync_2ff.sv ----
// two flip-flop level synchroniser
// assumes the input is a level that holds for more than two destination clocks
module sync_2ff #(
	parameter int           WIDTH = 1,
	parameter logic [0:0]   INIT  = 1'b0
) (
	input  wire logic             clk,   // destination clock
	input  wire logic             srst,  // synchronous reset, active high
	input  wire logic [WIDTH-1:0] d,     // asynchronous level
	output logic      [WIDTH-1:0] q      // synchronised level
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= {WIDTH{INIT}};
			q        <= {WIDTH{INIT}};
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule // sync_2ff

// ---- rtl/spi_config_port_shadow_regs.sv ----
// serial configuration port with shadowed function registers
// assumes sclk comes from the host and stands still while port_select_n is high;
// the host waits at least three clk periods between the fall of port_select_n and the first sclk rise
// Function
// - cycles accepted only while select is low
// - frame starts at first rising clock after select falls
// - select held low streams consecutive bytes
// - select high between bytes pauses, then resumes
// - select high floats data pin; held past the stall limit, enables secondary functions
// - all serial data moves in eight-bit words
// - first instruction bit picks read or write
// - read turns data pin to output after instruction
// - clock and select inputs; host releases pin on reads
// - most significant bit first after power-up
// - order bit one: lsb first, address increments
// - order bit zero: msb first, address decrements
// - soft reset bit restores port defaults, self-clears
// - configuration register resets 0x18, reports 13-bit addressing
// - function writes land in shadows until transfer
// - transfer copies all shadows at once, self-clears
// - device reset loads every default value
// - decoder maps 0x000-0x002, 0x0ff, 0x008-0x13a
`include "spi_cfg_defs.svh"

module spi_config_port_shadow_regs #(
	parameter int         FUNC_REGS    = `FUNC_REG_COUNT, // function registers from the first function address
	parameter int         STALL_CYCLES = `STALL_CYCLES,   // clk cycles of select-high that end a frame
	parameter logic [7:0] CHIP_ID      = 8'h5a,           // identity value, arbitrary
	parameter logic [7:0] CHIP_GRADE   = 8'h00,           // grade value, arbitrary
	parameter logic [7:0] FUNC_DEFAULT = 8'h00            // reset value of every function register
) (
	input  wire logic                       clk,           // converter-side clock
	input  wire logic                       srst,          // synchronous reset, active high
	input  wire logic                       sclk,          // serial clock from the host
	input  wire logic                       port_select_n, // frame select, active low
	input  wire logic                       sdio_in,       // data pin, level seen
	output logic                            sdio_out,      // data pin, level driven
	output logic                            sdio_oe,       // data pin, high while driving
	output logic                            secondary_en,  // pins free for secondary use
	output spi_cfg_pkg::port_status_t       status,        // port state, clk domain
	output logic [FUNC_REGS*8-1:0]          active_regs    // function registers in use
);
	import spi_cfg_pkg::*;

	localparam int IDX_W = `SPI_ADDR_W;
	localparam int CNT_W = $clog2(STALL_CYCLES + 1) + 1;

	////////////////////////////////////////////////////////////////////////////////
	// converter-clock side: resets for the link, stall timer, crossings

	logic             link_rst_reg;    // whole-port reset into the link domain
	logic             frame_rst_reg;   // frame-state reset into the link domain
	logic             idle_reg;
	logic [CNT_W-1:0] stall_cnt_reg;
	logic             sel_high_s;
	logic             xfer_tgl_s;
	logic             xfer_seen_reg;
	logic             lsb_first_s;
	logic [FUNC_REGS*8-1:0] active_reg;

	// select level into clk, high at reset so the port starts idle
	sync_2ff #(.WIDTH(1), .INIT(1'b1)) u_sel_sync (
		.clk  (clk),
		.srst (srst),
		.d    (port_select_n),
		.q    (sel_high_s)
	);

	always_ff @(posedge clk) begin
		if (srst)
			link_rst_reg <= 1'b1;
		else
			link_rst_reg <= 1'b0;
	end

	// short gaps keep the frame
	// a gap shorter than the limit is a byte stall; a longer one ends the frame
	always_ff @(posedge clk) begin
		if (srst) begin
			stall_cnt_reg <= '0;
			idle_reg      <= 1'b1;
		end else if (!sel_high_s) begin
			stall_cnt_reg <= '0;
			idle_reg      <= 1'b0;
		end else if (stall_cnt_reg >= CNT_W'(STALL_CYCLES)) begin
			idle_reg      <= 1'b1;
		end else begin
			stall_cnt_reg <= stall_cnt_reg + 1'b1;
		end
	end

	// a new frame after a long gap
	// one register drives the async reset so no gate can glitch it
	always_ff @(posedge clk) begin
		if (srst)
			frame_rst_reg <= 1'b1;
		else
			frame_rst_reg <= (sel_high_s && stall_cnt_reg >= CNT_W'(STALL_CYCLES)) || (idle_reg && sel_high_s);
	end

	assign secondary_en = idle_reg;

	logic xfer_tgl_reg;
	logic lsb_first_reg;
	logic [FUNC_REGS*8-1:0] shadow_reg;

	// transfer request toggle into clk
	sync_2ff #(.WIDTH(1), .INIT(1'b0)) u_xfer_sync (
		.clk  (clk),
		.srst (srst),
		.d    (xfer_tgl_reg),
		.q    (xfer_tgl_s)
	);

	// bit order into clk for status only
	sync_2ff #(.WIDTH(1), .INIT(1'b0)) u_order_sync (
		.clk  (clk),
		.srst (srst),
		.d    (lsb_first_reg),
		.q    (lsb_first_s)
	);

	// copy every shadow at once
	// shadows are quiet here: the request toggles after the write byte, and
	// the host cannot finish another byte within the three-cycle crossing
	always_ff @(posedge clk) begin
		if (srst) begin
			active_reg    <= {FUNC_REGS{FUNC_DEFAULT}};
			xfer_seen_reg <= 1'b0;
		end else if (xfer_tgl_s != xfer_seen_reg) begin
			active_reg    <= shadow_reg;
			xfer_seen_reg <= xfer_tgl_s;
		end
	end

	assign active_regs = active_reg;

	// status: lsb_first and port_idle straight from flops, xfer_busy an XOR of two flops
	assign status.lsb_first = lsb_first_s;
	assign status.xfer_busy = xfer_tgl_s ^ xfer_seen_reg;
	assign status.port_idle = idle_reg;

	////////////////////////////////////////////////////////////////////////////////
	// link side: framing on sclk

	link_phase_t      phase_reg;
	logic [3:0]       bit_cnt_reg;
	logic [15:0]      shift_reg;
	logic [15:0]      shift_next;
	logic             rd_reg;
	logic [IDX_W-1:0] addr_reg;
	logic [IDX_W-1:0] addr_next;
	logic [7:0]       rd_byte_reg;
	logic [7:0]       rd_mux;
	logic [IDX_W-1:0] mux_addr;
	logic             sel_low;
	logic             instr_done;
	logic             byte_done;
	logic             wr_en;
	logic [7:0]       wr_byte;
	logic             xfer_ack_s;
	instr_t           instr_word;

	assign sel_low = !port_select_n;

	// read flag is the first bit
	assign instr_word = instr_t'(shift_next);

	assign instr_done = sel_low && phase_reg == PH_INSTR && bit_cnt_reg == `INSTR_LAST;

	assign byte_done = sel_low && phase_reg == PH_DATA && bit_cnt_reg == `BYTE_LAST;
	assign wr_en     = byte_done && !rd_reg;
	assign wr_byte   = shift_next[7:0];

	// lsb first fills from the top
	// msb first fills from the bottom
	// the instruction itself always arrives first bit first
	always_comb begin
		if (phase_reg == PH_DATA && lsb_first_reg)
			shift_next = {8'h00, sdio_in, shift_reg[7:1]};
		else
			shift_next = {shift_reg[14:0], sdio_in};
	end

	always_comb begin
		if (lsb_first_reg)
			addr_next = addr_reg + 1'b1;
		else
			addr_next = addr_reg - 1'b1;
	end

	// data phase repeats until the frame ends
	always_ff @(posedge sclk or posedge frame_rst_reg) begin
		if (frame_rst_reg) begin
			phase_reg   <= PH_INSTR;
			bit_cnt_reg <= 4'h0;
		end else if (instr_done || byte_done) begin
			phase_reg   <= PH_DATA;
			bit_cnt_reg <= 4'h0;
		end else if (sel_low) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// shift register, cleared per byte in the data phase
	always_ff @(posedge sclk or posedge frame_rst_reg) begin
		if (frame_rst_reg)
			shift_reg <= 16'h0000;
		else if (instr_done || byte_done)
			shift_reg <= 16'h0000;
		else if (sel_low)
			shift_reg <= shift_next;
	end

	// instruction latch and running address
	always_ff @(posedge sclk or posedge frame_rst_reg) begin
		if (frame_rst_reg) begin
			rd_reg   <= 1'b0;
			addr_reg <= '0;
		end else if (instr_done) begin
			rd_reg   <= instr_word.rd;
			addr_reg <= instr_word.addr;
		end else if (byte_done) begin
			addr_reg <= addr_next;
		end
	end

	// read decode
	// unmapped and unimplemented addresses read as zero
	assign mux_addr = instr_done ? instr_word.addr : addr_next;

	always_comb begin
		rd_mux = 8'h00;
		case (mux_addr)
			`REG_PORT_CFG: begin
				rd_mux = `CFG_ADDR13_MASK;
				rd_mux[`CFG_LSB_HI] = lsb_first_reg;
				rd_mux[`CFG_LSB_LO] = lsb_first_reg;
			end
			`REG_CHIP_ID:    rd_mux = CHIP_ID;
			`REG_CHIP_GRADE: rd_mux = CHIP_GRADE;
			`REG_SHADOW_XFER: begin
				rd_mux[`XFER_BIT] = xfer_tgl_reg ^ xfer_ack_s;
			end
			default: begin
				if (mux_addr >= `REG_FUNC_FIRST && mux_addr <= `REG_FUNC_LAST &&
						int'(mux_addr - `REG_FUNC_FIRST) < FUNC_REGS)
					rd_mux = shadow_reg[int'(mux_addr - `REG_FUNC_FIRST)*8 +: 8];
			end
		endcase
	end

	// read byte loaded at each word boundary
	always_ff @(posedge sclk or posedge frame_rst_reg) begin
		if (frame_rst_reg)
			rd_byte_reg <= 8'h00;
		else if (instr_done || byte_done)
			rd_byte_reg <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////////////
	// link side: driving the data pin

	logic       oe_reg;
	logic       out_reg;
	logic [2:0] out_idx;

	assign out_idx = lsb_first_reg ? bit_cnt_reg[2:0] : 3'(`BYTE_LAST - bit_cnt_reg);

	always_ff @(negedge sclk or posedge frame_rst_reg) begin
		if (frame_rst_reg) begin
			oe_reg  <= 1'b0;
			out_reg <= 1'b0;
		end else if (sel_low && phase_reg == PH_DATA && rd_reg) begin
			oe_reg  <= 1'b1;
			out_reg <= rd_byte_reg[out_idx];
		end else begin
			oe_reg  <= 1'b0;
		end
	end

	// float the pin while select is high
	// pin drives only in read data phases
	assign sdio_oe  = oe_reg && sel_low;
	assign sdio_out = out_reg;

	////////////////////////////////////////////////////////////////////////////////
	// link side: register bank

	// transfer completion back into the link domain; only advances on sclk,
	// so the pending flag reads stale until the host clocks again
	sync_2ff #(.WIDTH(1), .INIT(1'b0)) u_ack_sync (
		.clk  (sclk),
		.srst (link_rst_reg),
		.d    (xfer_seen_reg),
		.q    (xfer_ack_s)
	);

	// soft reset wins over the order bits
	always_ff @(posedge sclk or posedge link_rst_reg) begin
		if (link_rst_reg)
			lsb_first_reg <= 1'b0;
		else if (wr_en && addr_reg == `REG_PORT_CFG) begin
			if (wr_byte[`CFG_SRST_HI] || wr_byte[`CFG_SRST_LO])
				lsb_first_reg <= 1'b0;
			else
				lsb_first_reg <= wr_byte[`CFG_LSB_HI] || wr_byte[`CFG_LSB_LO];
		end
	end

	// transfer request toggle
	// bit reads one while the copy is in flight, then clears itself
	always_ff @(posedge sclk or posedge link_rst_reg) begin
		if (link_rst_reg)
			xfer_tgl_reg <= 1'b0;
		else if (wr_en && addr_reg == `REG_SHADOW_XFER && wr_byte[`XFER_BIT] &&
				xfer_tgl_reg == xfer_ack_s)
			xfer_tgl_reg <= ~xfer_tgl_reg;
	end

	always_ff @(posedge sclk or posedge link_rst_reg) begin
		if (link_rst_reg)
			shadow_reg <= {FUNC_REGS{FUNC_DEFAULT}};
		else if (wr_en && addr_reg >= `REG_FUNC_FIRST && addr_reg <= `REG_FUNC_LAST &&
				addr_reg != `REG_SHADOW_XFER && int'(addr_reg - `REG_FUNC_FIRST) < FUNC_REGS)
			shadow_reg[int'(addr_reg - `REG_FUNC_FIRST)*8 +: 8] <= wr_byte;
	end

	// unused bits are stored as written
	// no noise gating is done here

endmodule // spi_config_port_shadow_regs

// ---- verification/spi_cfg_checker.sv ----
// assertions on the ports of the serial configuration port
// assumes sclk stands still outside frames and srst covers both domains
module spi_cfg_checker #(
	parameter int FUNC_REGS    = 4, // function registers
	parameter int STALL_CYCLES = 8  // select-high limit
) (
	input wire logic                      clk,           // converter clock
	input wire logic                      srst,          // reset, active high
	input wire logic                      sclk,          // link clock
	input wire logic                      port_select_n, // frame select
	input wire logic                      sdio_in,       // pin level
	input wire logic                      sdio_out,      // device drive
	input wire logic                      sdio_oe,       // device enable
	input wire logic                      secondary_en,  // pins released
	input wire spi_cfg_pkg::port_status_t status,        // port state
	input wire logic [FUNC_REGS*8-1:0]    active_regs    // live registers
);
	timeunit 1ns;
	timeprecision 100ps;
	import spi_cfg_pkg::*;
	int   hi_cnt;
	int   bit_cnt;
	logic rd_bit;
	////////////////////////////////////////////////////////////////////////////
	// select-high time, saturated so it never wraps
	always_ff @(posedge clk) begin
		if (srst || !port_select_n) hi_cnt <= 0;
		else if (hi_cnt < 1000) hi_cnt <= hi_cnt + 1;
	end
	// frame bit count; cleared by idle because sclk gives no edge then
	always_ff @(posedge sclk or posedge secondary_en) begin
		if (secondary_en) bit_cnt <= 0;
		else if (!port_select_n && bit_cnt < 64) bit_cnt <= bit_cnt + 1;
	end
	always_ff @(posedge sclk) begin
		if (!port_select_n && bit_cnt == 0) rd_bit <= sdio_in;
	end
	////////////////////////////////////////////////////////////////////////////
	sequence busy_clears;
		##[1:12] !status.xfer_busy;
	endsequence
	oe_gated_a: assert property (@(posedge clk) disable iff (srst)
		port_select_n |-> !sdio_oe) else $error("pin driven while deselected");
	// select low for four clocks must keep the port awake, however it paused in between
	idle_mirror_a: assert property (@(posedge clk) disable iff (srst)
		!port_select_n && !$past(port_select_n, 4) |-> !secondary_en && secondary_en == status.port_idle)
		else $error("port idle while selected");
	idle_limit_a: assert property (@(posedge clk) disable iff (srst)
		hi_cnt >= STALL_CYCLES + 6 |-> secondary_en) else $error("port not idle");
	select_wake_a: assert property (@(posedge clk) disable iff (srst)
		$fell(port_select_n) |-> ##[1:4] !secondary_en) else $error("select ignored");
	shadow_hold_a: assert property (@(posedge clk) disable iff (srst)
		$changed(active_regs) |-> status.xfer_busy || $past(status.xfer_busy))
		else $error("live registers changed without transfer");
	xfer_clear_a: assert property (@(posedge clk) disable iff (srst)
		$rose(status.xfer_busy) |-> busy_clears) else $error("transfer stuck");
	instr_quiet_a: assert property (@(posedge sclk) disable iff (srst)
		bit_cnt < 16 |-> !sdio_oe) else $error("pin driven in instruction");
	write_quiet_a: assert property (@(posedge sclk) disable iff (srst)
		bit_cnt >= 16 && !rd_bit |-> !sdio_oe) else $error("pin driven in write");
	read_drive_a: assert property (@(posedge sclk) disable iff (srst)
		bit_cnt >= 16 && rd_bit && !port_select_n |-> sdio_oe) else $error("read not driven");
endmodule // spi_cfg_checker

bind spi_config_port_shadow_regs spi_cfg_checker #(
	.FUNC_REGS   (FUNC_REGS),
	.STALL_CYCLES(STALL_CYCLES)
) checker_i (
	.clk          (clk),
	.srst         (srst),
	.sclk         (sclk),
	.port_select_n(port_select_n),
	.sdio_in      (sdio_in),
	.sdio_out     (sdio_out),
	.sdio_oe      (sdio_oe),
	.secondary_en (secondary_en),
	.status       (status),
	.active_regs  (active_regs)
);

// ---- verification/spi_host_model.sv ----
// host side of the three-wire link: clock, select and the shared data pin
// assumes the bench calls its tasks one at a time
module spi_host_model (
	output logic      sclk,          // link clock, only within frames
	output logic      port_select_n, // frame select, active low
	output logic      sdio_in,       // resolved pin level
	input  wire logic sdio_out,      // device drive value
	input  wire logic sdio_oe        // device drives pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic h_oe;
	logic h_d;
	logic last;
	////////////////////////////////////////////////////////////////////////////
	// link idle between frames
	initial begin
		sclk = 1'b0;
		port_select_n = 1'b1;
		h_oe = 1'b1;
		h_d = 1'b0;
		last = 1'b0;
	end
	// no pull on the pin, so a released pin shows the inverse of its last level
	always_comb sdio_in = sdio_oe ? sdio_out : (h_oe ? h_d : ~last);
	always @(posedge sclk) last <= sdio_in;
	task automatic sel(input logic lvl, input int ns);
		port_select_n = lvl;
		#(ns);
	endtask
	task automatic xbyte(input logic [7:0] tx, input logic lsb, input logic drv, output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			h_oe = drv;
			h_d = tx[lsb ? i : 7 - i];
			#16;
			rx[lsb ? i : 7 - i] = sdio_in;
			sclk = 1'b1;
			#16;
			sclk = 1'b0;
		end
	endtask
endmodule // spi_host_model

// ---- verification/tb_top.sv ----
// self-checking bench for the serial configuration port
// assumes the host model drives the link pins and the bench owns clk and srst
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_cfg_pkg::*;
	localparam int         NR     = 4;
	localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
	localparam logic [7:0] GR_VAL = 8'h21; // arbitrary grade value
	logic            clk;
	logic            srst;
	logic            sclk;
	logic            port_select_n;
	logic            sdio_in;
	logic            sdio_out;
	logic            sdio_oe;
	logic            secondary_en;
	port_status_t    status;
	logic [NR*8-1:0] active_regs;
	logic [7:0]      dat [4];
	int              n_fail;
	int              n_compared;
	////////////////////////////////////////////////////////////////////////////
	spi_config_port_shadow_regs #(.FUNC_REGS(NR), .STALL_CYCLES(8), .CHIP_ID(ID_VAL), .CHIP_GRADE(GR_VAL)) dut (
		.clk(clk), .srst(srst), .sclk(sclk), .port_select_n(port_select_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .secondary_en(secondary_en), .status(status),
		.active_regs(active_regs));
	spi_host_model host (.sclk(sclk), .port_select_n(port_select_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe));
	// 50 MHz converter clock
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// frame to a mapped address: rw, length, address, n bytes
	task automatic access(input logic r, input logic [12:0] a, input int n, input logic lsb);
		logic [7:0] x;
		host.sel(1'b0, 100);
		host.xbyte({r, 2'b00, a[12:8]}, 1'b0, 1'b1, x);
		host.xbyte(a[7:0], 1'b0, 1'b1, x);
		for (int i = 0; i < n; i++) host.xbyte(dat[i], lsb, !r, dat[i]);
		host.sel(1'b1, 400);
	endtask
	task automatic t_reset();
		// mid-run entry comes at any time, so line up with the falling edge first
		@(negedge clk);
		srst = 1'b1;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk(secondary_en, 1, "idle");
		chk(status, 3'b001, "status");
		chk(active_regs, '0, "live defaults");
		access(1'b1, 13'h002, 3, 1'b0);
		chk({dat[0], dat[1], dat[2]}, {GR_VAL, ID_VAL, 8'h18}, "chip regs");
	endtask
	task automatic t_stream();
		dat = '{8'h11, 8'h22, 8'h33, 8'h00};
		access(1'b0, 13'h00b, 3, 1'b0);
		chk(active_regs, '0, "shadow only");
		access(1'b1, 13'h00b, 3, 1'b0);
		chk({dat[0], dat[1], dat[2]}, 24'h112233, "stream down");
		dat[0] = 8'hff;
		access(1'b0, 13'h001, 1, 1'b0);
		access(1'b1, 13'h001, 1, 1'b0);
		chk(dat[0], ID_VAL, "read-only id");
	endtask
	// select-high pause between bytes must resume the same write
	task automatic t_stall();
		logic [7:0] x;
		host.sel(1'b0, 100);
		host.xbyte(8'h00, 1'b0, 1'b1, x);
		host.xbyte(8'h09, 1'b0, 1'b1, x);
		host.xbyte(8'h44, 1'b0, 1'b1, x);
		host.sel(1'b1, 60);
		host.sel(1'b0, 100);
		host.xbyte(8'h55, 1'b0, 1'b1, x);
		host.sel(1'b1, 400);
		access(1'b1, 13'h009, 2, 1'b0);
		chk({dat[0], dat[1]}, 16'h4455, "stall resume");
	endtask
	task automatic t_xfer();
		dat[0] = 8'h01;
		access(1'b0, 13'h0ff, 1, 1'b0);
		chk(active_regs, 32'h11224455, "copy all");
		access(1'b1, 13'h0ff, 1, 1'b0);
		chk(dat[0][0], 1'b0, "self clear");
	endtask
	task automatic t_order();
		dat[0] = 8'h42;
		access(1'b0, 13'h000, 1, 1'b0);
		chk(status.lsb_first, 1'b1, "lsb mode");
		access(1'b1, 13'h000, 1, 1'b1);
		chk(dat[0], 8'h5a, "mirrored bits");
		dat = '{8'h01, 8'h03, 8'h00, 8'h00};
		access(1'b0, 13'h00a, 2, 1'b1);
		dat[0] = 8'h24;
		access(1'b0, 13'h000, 1, 1'b1);
		chk(status.lsb_first, 1'b0, "soft reset");
		access(1'b1, 13'h00b, 2, 1'b0);
		chk({dat[0], dat[1]}, 16'h0301, "lsb up");
		access(1'b1, 13'h000, 1, 1'b0);
		chk(dat[0], 8'h18, "config default");
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// main sequence, second reset mid-run, watchdog well past the ~24 us of traffic
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		n_fail = 0;
		n_compared = 0;
		fork
			begin
				#200us;
				n_fail++;
				give_verdict();
			end
		join_none
		t_reset();
		t_stream();
		t_stall();
		t_xfer();
		t_order();
		t_reset();
		give_verdict();
	end
endmodule // tb_top
